/* hdl/xpc_consts.svh */
// Timing counts and field positions for the crosspoint controller
`ifndef XPC_CONSTS_SVH
`define XPC_CONSTS_SVH
`define XPC_CLK_NS        10
`define XPC_T_SETUP_NS    15
`define XPC_T_PULSE_NS    10
`define XPC_T_HOLD_NS     5
`define XPC_T_SETTLE_NS   70
`define XPC_CYC_MIN(ns)   (((ns) + `XPC_CLK_NS - 1) / `XPC_CLK_NS)
`define XPC_SETUP_CYC     `XPC_CYC_MIN(`XPC_T_SETUP_NS)
`define XPC_PULSE_CYC     `XPC_CYC_MIN(`XPC_T_PULSE_NS)
`define XPC_HOLD_CYC      `XPC_CYC_MIN(`XPC_T_HOLD_NS)
`define XPC_SETTLE_CYC    `XPC_CYC_MIN(`XPC_T_SETTLE_NS)
`define XPC_CNT_W         4
`define XPC_ENTRY_HIZ     0
`endif

/* hdl/xpc_pkg.sv */
// Types shared by the crosspoint controller
package xpc_pkg;
    typedef logic [2:0] xpc_port_t;
    typedef enum logic [1:0] {
        XPC_OP_LOAD   = 2'h0,
        XPC_OP_APPLY  = 2'h1,
        XPC_OP_PRESET = 2'h2
    } xpc_op_t;
    typedef enum logic [4:0] {
        XPC_IDLE   = 5'h01,
        XPC_SETUP  = 5'h02,
        XPC_PULSE  = 5'h04,
        XPC_HOLD   = 5'h08,
        XPC_SETTLE = 5'h10
    } xpc_state_t;
endpackage

/* hdl/xpc_sync.sv */
// Three-stage synchroniser for one level arriving from outside the clock
`timescale 1ns/100ps
module xpc_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_o <= 1'b0;
        end else if (s2 == s3) begin
            q_o <= s3;
        end
    end
endmodule

/* hdl/xpc_ctrl.sv */
// Controller that programs an 8x8 crosspoint through its strobe pins
`timescale 1ns/100ps
`include "xpc_consts.svh"
module xpc_ctrl (
    input  wire logic            clk_i,
    input  wire logic            nrst_i,
    input  wire logic            req_valid_i,
    output logic                 req_ready_o,
    input  wire xpc_pkg::xpc_op_t   req_op_i,
    input  wire xpc_pkg::xpc_port_t req_src_i,
    input  wire xpc_pkg::xpc_port_t req_dst_i,
    input  wire logic            req_hiz_i,
    input  wire logic            dev_sel_req_i,
    input  wire logic            busy_ext_i,
    output logic                 done_o,
    output logic                 busy_o,
    output logic [2:0]           src_sel_o,
    output logic [2:0]           dst_sel_o,
    output logic                 hiz_req_o,
    output logic                 dev_sel_o,
    output logic                 load_strobe_o,
    output logic                 apply_strobe_o,
    output logic                 preset_pulse_o,
    output logic [31:0]          shadow_o
);
    import xpc_pkg::*;

    localparam logic [`XPC_CNT_W-1:0] SETUP_N  = `XPC_CNT_W'(`XPC_SETUP_CYC);
    localparam logic [`XPC_CNT_W-1:0] PULSE_N  = `XPC_CNT_W'(`XPC_PULSE_CYC);
    localparam logic [`XPC_CNT_W-1:0] HOLD_N   = `XPC_CNT_W'(`XPC_HOLD_CYC);
    localparam logic [`XPC_CNT_W-1:0] SETTLE_N = `XPC_CNT_W'(`XPC_SETTLE_CYC);

    xpc_state_t             state;
    xpc_state_t             next_state;
    logic [`XPC_CNT_W-1:0]  cnt;
    logic [`XPC_CNT_W-1:0]  next_cnt;
    xpc_op_t                op;
    logic                   hold_ext;
    logic [3:0]             load_rank [8];

    // ==================================================================
    // External busy level, from another domain
    xpc_sync u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (busy_ext_i),
        .q_o    (hold_ext)
    );

    assign req_ready_o = (state == XPC_IDLE) && !hold_ext;
    assign busy_o      = (state != XPC_IDLE);

    // ==================================================================
    // Sequencer: setup, strobe pulse, hold, then settle for applies and presets
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            XPC_IDLE: begin
                if (req_valid_i && req_ready_o) begin
                    next_state = XPC_SETUP;
                    next_cnt   = SETUP_N;
                end
            end
            XPC_SETUP: begin
                if (cnt <= `XPC_CNT_W'(1)) begin
                    next_state = XPC_PULSE;
                    next_cnt   = PULSE_N;
                end else begin
                    next_cnt = cnt - `XPC_CNT_W'(1);
                end
            end
            XPC_PULSE: begin
                if (cnt <= `XPC_CNT_W'(1)) begin
                    next_state = XPC_HOLD;
                    next_cnt   = HOLD_N;
                end else begin
                    next_cnt = cnt - `XPC_CNT_W'(1);
                end
            end
            XPC_HOLD: begin
                if (cnt <= `XPC_CNT_W'(1)) begin
                    next_state = (op == XPC_OP_LOAD) ? XPC_IDLE : XPC_SETTLE;
                    next_cnt   = SETTLE_N;
                end else begin
                    next_cnt = cnt - `XPC_CNT_W'(1);
                end
            end
            XPC_SETTLE: begin
                if (cnt <= `XPC_CNT_W'(1)) begin
                    next_state = XPC_IDLE;
                end else begin
                    next_cnt = cnt - `XPC_CNT_W'(1);
                end
            end
            default: begin
                next_state = XPC_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= XPC_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ==================================================================
    // Pin buses held stable from setup through hold
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op        <= XPC_OP_LOAD;
            src_sel_o <= 3'h0;
            dst_sel_o <= 3'h0;
            hiz_req_o <= 1'b0;
            dev_sel_o <= 1'b0;
        end else if (state == XPC_IDLE && req_valid_i && req_ready_o) begin
            op        <= req_op_i;
            src_sel_o <= req_src_i;
            dst_sel_o <= req_dst_i;
            hiz_req_o <= req_hiz_i;
            dev_sel_o <= dev_sel_req_i;
        end else if (state == XPC_IDLE) begin
            dev_sel_o <= 1'b0;
        end
    end

    // ==================================================================
    // Strobes, registered, high only during the pulse phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            load_strobe_o  <= 1'b0;
            apply_strobe_o <= 1'b0;
            preset_pulse_o <= 1'b0;
        end else begin
            load_strobe_o  <= (next_state == XPC_PULSE)
                              && (op == XPC_OP_LOAD);
            apply_strobe_o <= (next_state == XPC_PULSE)
                              && (op == XPC_OP_APPLY);
            preset_pulse_o <= (next_state == XPC_PULSE)
                              && (op == XPC_OP_PRESET);
        end
    end

    assign done_o = (state != XPC_IDLE) && (next_state == XPC_IDLE);

    // ==================================================================
    // Shadow of what the device's configuration rank should hold
    logic [3:0] cfg_rank [8];
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 8; i++) begin
                load_rank[i] <= 4'h0;
                cfg_rank[i]  <= 4'h0;
            end
        end else if (dev_sel_o && preset_pulse_o) begin
            for (int i = 0; i < 8; i++) begin
                load_rank[i] <= {3'h0, hiz_req_o};
                cfg_rank[i]  <= {3'h0, hiz_req_o};
            end
        end else if (dev_sel_o && load_strobe_o) begin
            load_rank[dst_sel_o] <= {src_sel_o, hiz_req_o};
        end else if (dev_sel_o && apply_strobe_o) begin
            for (int i = 0; i < 8; i++) begin
                cfg_rank[i] <= load_rank[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            shadow_o[4*i +: 4] = cfg_rank[i];
        end
    end

    // ==================================================================
    // Assertions
    sequence s_pulse_n;
        (load_strobe_o || apply_strobe_o || preset_pulse_o) [*1];
    endsequence

    a_one_strobe: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $onehot0({load_strobe_o, apply_strobe_o, preset_pulse_o}))
        else $error("More than one strobe high");

    a_buses_stable: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_pulse_n |-> $stable(src_sel_o) && $stable(dst_sel_o)
                      && $stable(hiz_req_o) && $stable(dev_sel_o))
        else $error("Pin buses moved during strobe");

    a_setup_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(load_strobe_o) |-> $past(state == XPC_SETUP))
        else $error("Load strobe without setup");

    a_strobe_ends: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(load_strobe_o) |-> ##[1:2] !load_strobe_o)
        else $error("Load strobe too long");

    a_hold_after: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(load_strobe_o) |-> $stable(src_sel_o)
                                 && $stable(hiz_req_o))
        else $error("Data changed at strobe fall");

    a_preset_hiz: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dev_sel_o && preset_pulse_o && hiz_req_o
        |=> shadow_o == 32'h11111111)
        else $error("Preset with hiz did not disable");

    a_preset_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dev_sel_o && preset_pulse_o && !hiz_req_o
        |=> shadow_o == 32'h0)
        else $error("Preset did not route to input 0");

    a_no_sel_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !dev_sel_o |=> $stable(shadow_o))
        else $error("Ranks changed without select");

    a_apply_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !(dev_sel_o && (apply_strobe_o || preset_pulse_o))
        |=> $stable(shadow_o))
        else $error("Routing changed without apply");
endmodule

/* sim/xpc_dev_model.sv */
// Behavioural model of the crosspoint's two latch ranks
`timescale 1ns/100ps
module xpc_dev_model (
    input  wire logic        dev_sel_i,
    input  wire logic [2:0]  src_sel_i,
    input  wire logic [2:0]  dst_sel_i,
    input  wire logic        hiz_i,
    input  wire logic        load_i,
    input  wire logic        apply_i,
    input  wire logic        preset_i,
    output logic      [31:0] ld_o,
    output logic      [31:0] cfg_o
);
    logic [31:0] ld;
    logic [31:0] cfg;
    assign ld_o  = ld;
    assign cfg_o = cfg;
    // ==========
    // Load rank: transparent while load is high
    always @(load_i, dev_sel_i, src_sel_i, dst_sel_i, hiz_i) begin
        if (load_i && dev_sel_i) begin
            ld[dst_sel_i * 4 +: 4] = {src_sel_i, hiz_i};
        end
    end
    // ==========
    // Configuration rank: transparent while apply is high
    always @(apply_i, dev_sel_i, ld) begin
        if (apply_i && dev_sel_i) begin
            cfg = ld;
        end
    end
    // Preset of both ranks
    always @(posedge preset_i) begin
        if (dev_sel_i) begin
            ld  = {8{3'h0, hiz_i}};
            cfg = ld;
        end
    end
endmodule

/* sim/tb_xpc_ctrl.sv */
// Self-checking bench for the crosspoint controller
`timescale 1ns/100ps
module tb_xpc_ctrl;
    import xpc_pkg::*;
    logic        clk_i, nrst_i, req_valid_i, req_ready_o, req_hiz_i;
    xpc_op_t     req_op_i;
    xpc_port_t   req_src_i, req_dst_i;
    logic        dev_sel_req_i, busy_ext_i, done_o, busy_o, hiz_req_o;
    logic [2:0]  src_sel_o, dst_sel_o;
    logic        dev_sel_o, load_strobe_o, apply_strobe_o, preset_pulse_o;
    logic [31:0] shadow_o, dev_ld, dev_cfg, exp_ld, exp_cfg;
    int          n_fail, comparisons;

    xpc_ctrl xpc_ctrl_i (.clk_i(clk_i), .nrst_i(nrst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_op_i(req_op_i), .req_src_i(req_src_i), .req_dst_i(req_dst_i),
        .req_hiz_i(req_hiz_i), .dev_sel_req_i(dev_sel_req_i),
        .busy_ext_i(busy_ext_i), .done_o(done_o), .busy_o(busy_o),
        .src_sel_o(src_sel_o), .dst_sel_o(dst_sel_o), .hiz_req_o(hiz_req_o),
        .dev_sel_o(dev_sel_o), .load_strobe_o(load_strobe_o),
        .apply_strobe_o(apply_strobe_o), .preset_pulse_o(preset_pulse_o),
        .shadow_o(shadow_o));
    xpc_dev_model xpc_dev_model_i (.dev_sel_i(dev_sel_o),
        .src_sel_i(src_sel_o), .dst_sel_i(dst_sel_o), .hiz_i(hiz_req_o),
        .load_i(load_strobe_o), .apply_i(apply_strobe_o),
        .preset_i(preset_pulse_o), .ld_o(dev_ld), .cfg_o(dev_cfg));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Expected ranks after one command
    function automatic void predict(input logic [1:0] op,
        input logic [2:0] s, input logic [2:0] d, input logic h,
        input logic sel);
        if (sel) begin
            case (op)
                2'h0: exp_ld[d * 4 +: 4] = {s, h};
                2'h1: exp_cfg = exp_ld;
                default: begin
                    exp_ld  = {8{3'h0, h}};
                    exp_cfg = exp_ld;
                end
            endcase
        end
    endfunction

    task automatic do_cmd(input logic [1:0] op, input logic [2:0] s,
        input logic [2:0] d, input logic h, input logic sel);
        int n;
        @(posedge clk_i);
        req_valid_i   <= 1'b1;
        req_op_i      <= xpc_op_t'(op);
        req_src_i     <= s;
        req_dst_i     <= d;
        req_hiz_i     <= h;
        dev_sel_req_i <= sel;
        n = 0;
        do @(negedge clk_i); while (req_ready_o !== 1'b1 && ++n < 60);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        do @(negedge clk_i); while (done_o !== 1'b1 && ++n < 40);
        if (n >= 40) check("done", 32'h0, 32'h1);
        @(posedge clk_i);
        @(negedge clk_i);
        predict(op, s, d, h, sel);
        check("load rank", dev_ld, exp_ld);
        check("config rank", dev_cfg, exp_cfg);
        check("shadow", shadow_o, exp_cfg);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        summarize();
    end

    initial begin
        n_fail = 0;
        comparisons = 0;
        nrst_i = 1'b0;
        req_valid_i = 1'b0;
        req_op_i = XPC_OP_LOAD;
        req_src_i = 3'h0;
        req_dst_i = 3'h0;
        req_hiz_i = 1'b0;
        dev_sel_req_i = 1'b0;
        busy_ext_i = 1'b0;
        void'($urandom(2210));
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        do_cmd(2'h2, 3'h0, 3'h0, 1'b1, 1'b1);
        do_cmd(2'h2, 3'h0, 3'h0, 1'b0, 1'b1);
        do_cmd(2'h0, 3'h6, 3'h1, 1'b0, 1'b1);
        do_cmd(2'h0, 3'h3, 3'h7, 1'b1, 1'b1);
        do_cmd(2'h1, 3'h0, 3'h0, 1'b0, 1'b1);
        for (int d = 0; d < 8; d++) begin
            do_cmd(2'h0, 3'h5, 3'(d), 1'b0, 1'b1);
        end
        do_cmd(2'h1, 3'h0, 3'h0, 1'b0, 1'b0);
        do_cmd(2'h2, 3'h0, 3'h0, 1'b1, 1'b0);
        do_cmd(2'h1, 3'h0, 3'h0, 1'b0, 1'b1);
        @(posedge clk_i);
        busy_ext_i <= 1'b1;
        // Let the busy level pass the synchroniser before asking
        repeat (5) @(posedge clk_i);
        fork
            do_cmd(2'h0, 3'h2, 3'h4, 1'b0, 1'b1);
            begin
                repeat (8) @(negedge clk_i);
                check("ready", {31'h0, req_ready_o}, 32'h0);
                check("busy", {31'h0, busy_o}, 32'h0);
                @(posedge clk_i);
                busy_ext_i <= 1'b0;
            end
        join
        repeat (60) begin
            do_cmd(2'($urandom_range(2, 0)), 3'($urandom), 3'($urandom),
                   1'($urandom), 1'($urandom_range(3, 0) != 0));
        end
        summarize();
    end
endmodule
